/* File: logic/cmt_console_poller.sv */
// console monitor entry, init print and polled terminal sequencer
// assumes: cpu strobes on pclk; pins and backplane ack are asynchronous
`timescale 1ns/100ps
`include "cmt_consts.svh"
module cmt_console_poller (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic halt_exec,
  input wire logic kernel_mode,
  input wire logic macro_end,
  input wire logic [15:0] instruction_pointer,
  input wire logic halt_trap_jumper,
  input wire logic halt_request_line,
  input wire logic [1:0] power_up_mode,
  input wire logic bus_ack,
  input wire logic [15:0] bus_rdata,
  output logic bus_req,
  output logic [21:0] bus_addr,
  output logic bus_we,
  output logic [15:0] bus_wdata,
  output logic console_mode,
  output logic resume_pulse,
  output logic go_clear_ie,
  output logic sw_irq_req,
  output logic [21:0] loc_addr,
  output logic loc_virtual,
  output logic [15:0] loc_data,
  output logic deposit
);
  // ****************************************
  // synchronisers and entry sources
  // ****************************************
  logic [3:0] pin_s1_reg, pin_s2_reg;
  logic [1:0] pu_cnt_reg;
  logic pu_armed_reg, pu_req_reg, entry;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_reg <= 4'h0;
      pin_s2_reg <= 4'h0;
    end else if (ce) begin
      pin_s1_reg <= {power_up_mode, halt_request_line, halt_trap_jumper};
      pin_s2_reg <= pin_s1_reg;
    end
  end

  // strap caught once the synchroniser has settled after release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pu_cnt_reg <= 2'h0;
      pu_armed_reg <= 1'b1;
      pu_req_reg <= 1'b0;
    end else if (ce) begin
      pu_req_reg <= 1'b0;
      if (pu_cnt_reg != `CMT_PU_SETTLE) begin
        pu_cnt_reg <= pu_cnt_reg + 2'h1;
      end else if (pu_armed_reg) begin
        pu_armed_reg <= 1'b0;
        pu_req_reg <= (pin_s2_reg[3:2] == `CMT_PU_MODE_MON);
      end
    end
  end

  // bus errors and vector timeouts are not entry sources
  assign entry = (halt_exec && kernel_mode && pin_s2_reg[0])
    || (pin_s2_reg[1] && macro_end)
    || pu_req_reg;

  // ****************************************
  // apb registers
  // ****************************************
  logic virt_reg;
  logic [15:0] content_reg;
  cmt_pkg::cmt_main_t st_reg;
  cmt_pkg::cmt_parse_t ps_reg;
  logic [7:0] last_ch_reg;
  logic [21:0] addr_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b1;
      pslverr <= 1'b0;
      virt_reg <= 1'b0;
      content_reg <= 16'h0000;
      loc_virtual <= 1'b0;
    end else if (ce) begin
      loc_virtual <= virt_reg;
      if (psel && !penable) begin
        pslverr <= 1'b0;
        unique case (paddr)
          `CMT_OFF_CTRL: prdata <= {31'h0000_0000, virt_reg};
          `CMT_OFF_STATUS: prdata <= {17'h0_0000, st_reg, ps_reg, console_mode, last_ch_reg};
          `CMT_OFF_ADDR: prdata <= {10'h000, addr_reg};
          `CMT_OFF_CONTENT: prdata <= {16'h0000, content_reg};
          default: begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b1;
          end
        endcase
      end else if (psel && penable && pwrite) begin
        if (paddr == `CMT_OFF_CTRL) virt_reg <= pwdata[`CMT_CTRL_VIRT_BIT];
        if (paddr == `CMT_OFF_CONTENT) content_reg <= pwdata[15:0];
      end
    end
  end

  // ****************************************
  // character planning
  // ****************************************
  logic [7:0] q_reg [`CMT_QDEPTH];
  logic [7:0] ld_q [`CMT_QDEPTH];
  logic [3:0] ld_len, head_reg, len_reg;
  logic ld_exit, ld_go, ld_dep, loc_seen_reg, exit_reg, go_reg, xie_reg;
  cmt_pkg::cmt_parse_t ps_next;
  logic [21:0] addr_next;
  logic [15:0] data_reg, data_next, op_rdata;
  logic [6:0] ch7;
  logic op_start_reg, op_done;
  cmt_pkg::cmt_op_t op_reg;
  logic [7:0] op_wdata_reg;

  function automatic logic is_oct(input logic [6:0] c);
    is_oct = (c[6:3] == 4'h6);
  endfunction : is_oct

  function automatic logic [7:0] gen(input logic [6:0] c);
    gen = {1'b0, c};
  endfunction : gen

  function automatic logic [7:0] oct(input logic [15:0] v, input int k);
    logic [2:0] d;
    d = (k == 0) ? {2'b00, v[15]} : v[17 - 3 * k -: 3];
    oct = gen(`CMT_CH_ZERO + {4'h0, d});
  endfunction : oct

  always_comb begin
    ch7 = op_rdata[6:0];
    ld_q = '{default: 8'h00};
    ld_len = 4'h1;
    ld_exit = 1'b0;
    ld_go = 1'b0;
    ld_dep = 1'b0;
    ps_next = ps_reg;
    addr_next = addr_reg;
    data_next = data_reg;
    ld_q[0] = op_rdata[7:0];
    if (st_reg == cmt_pkg::M_IDLE) begin
      ld_q[0] = gen(`CMT_CH_CR);
      ld_q[1] = gen(`CMT_CH_LF);
      for (int k = 0; k < 6; k++) ld_q[2 + k] = oct(instruction_pointer, k);
      ld_q[8] = gen(`CMT_CH_CR);
      ld_q[9] = gen(`CMT_CH_LF);
      ld_q[10] = gen(`CMT_CH_AT);
      ld_len = 4'hb;
      ps_next = cmt_pkg::PS_PROMPT;
    end else begin
      ld_len = 4'h0;
      unique case (ps_reg)
        cmt_pkg::PS_PROMPT: begin
          if (is_oct(ch7)) begin
            ps_next = cmt_pkg::PS_ADDR;
            addr_next = {19'h0_0000, ch7[2:0]};
          end else if (ch7 == `CMT_CH_DOLLAR || ch7 == `CMT_CH_R) begin
            ps_next = cmt_pkg::PS_REGDES;
          end else if (ch7 == `CMT_CH_SLASH && loc_seen_reg) begin
            ps_next = cmt_pkg::PS_OPEN;
          end else if (ch7 == `CMT_CH_P) begin
            ld_exit = 1'b1;
          end
        end
        cmt_pkg::PS_ADDR: begin
          if (is_oct(ch7)) begin
            addr_next = {addr_reg[18:0], ch7[2:0]};
          end else if (ch7 == `CMT_CH_SLASH) begin
            ps_next = cmt_pkg::PS_OPEN;
          end else if (ch7 == `CMT_CH_G) begin
            ld_exit = 1'b1;
            ld_go = 1'b1;
          end
        end
        cmt_pkg::PS_REGDES: begin
          if (ch7[6:3] == 4'h6) begin
            ps_next = cmt_pkg::PS_REGNUM;
            addr_next = {19'h0_0000, ch7[2:0]};
          end else if (ch7 == `CMT_CH_S) begin
            ps_next = cmt_pkg::PS_REGNUM;
            addr_next = `CMT_ADDR_PSW;
          end
        end
        cmt_pkg::PS_REGNUM: if (ch7 == `CMT_CH_SLASH) ps_next = cmt_pkg::PS_OPEN;
        cmt_pkg::PS_OPEN, cmt_pkg::PS_DATA: begin
          if (is_oct(ch7)) begin
            ps_next = cmt_pkg::PS_DATA;
            data_next = {data_reg[12:0], ch7[2:0]};
          end else if (ch7 == `CMT_CH_CR || ch7 == `CMT_CH_LF) begin
            ps_next = cmt_pkg::PS_PROMPT;
            ld_dep = (ps_reg == cmt_pkg::PS_DATA);
          end
        end
        default: ps_next = cmt_pkg::PS_PROMPT;
      endcase
      if (ps_next == cmt_pkg::PS_OPEN && ps_reg != cmt_pkg::PS_OPEN) begin
        for (int k = 0; k < 6; k++) ld_q[1 + k] = oct(content_reg, k);
        ld_q[7] = gen(`CMT_CH_SP);
        ld_len = 4'h8;
        data_next = 16'h0000;
      end else if (ps_next == cmt_pkg::PS_PROMPT && ps_reg inside
          {cmt_pkg::PS_OPEN, cmt_pkg::PS_DATA}) begin
        ld_q[0] = gen(`CMT_CH_CR);
        ld_q[1] = gen(`CMT_CH_LF);
        ld_q[2] = gen(`CMT_CH_AT);
        ld_len = 4'h3;
        if (ch7 == `CMT_CH_CR) begin
          ld_q[1] = gen(`CMT_CH_CR);
          ld_q[2] = gen(`CMT_CH_LF);
          ld_q[3] = gen(`CMT_CH_AT);
          ld_len = 4'h4;
        end
      end else if (ps_next != ps_reg || ld_exit || ps_reg == cmt_pkg::PS_ADDR
          && is_oct(ch7) || ps_next == cmt_pkg::PS_DATA) begin
        ld_len = 4'h1;
      end else begin
        ld_q[0] = gen(`CMT_CH_QM);
        ld_q[1] = gen(`CMT_CH_CR);
        ld_q[2] = gen(`CMT_CH_LF);
        ld_q[3] = gen(`CMT_CH_AT);
        ld_len = 4'h4;
        ps_next = cmt_pkg::PS_PROMPT;
      end
    end
  end

  // ****************************************
  // polling sequencer
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= cmt_pkg::M_IDLE;
      ps_reg <= cmt_pkg::PS_PROMPT;
      q_reg <= '{default: 8'h00};
      head_reg <= 4'h0;
      len_reg <= 4'h0;
      op_start_reg <= 1'b0;
      op_reg <= cmt_pkg::OP_RX_STAT;
      op_wdata_reg <= 8'h00;
      addr_reg <= 22'h00_0000;
      data_reg <= 16'h0000;
      last_ch_reg <= 8'h00;
      {loc_seen_reg, exit_reg, go_reg, xie_reg} <= 4'h0;
      {console_mode, resume_pulse, go_clear_ie, sw_irq_req, deposit} <= 5'h00;
    end else if (ce) begin
      op_start_reg <= 1'b0;
      {resume_pulse, go_clear_ie, sw_irq_req, deposit} <= 4'h0;
      unique case (st_reg)
        cmt_pkg::M_IDLE: if (entry) begin
          q_reg <= ld_q;
          len_reg <= ld_len;
          head_reg <= 4'h0;
          ps_reg <= ps_next;
          exit_reg <= 1'b0;
          console_mode <= 1'b1;
          st_reg <= cmt_pkg::M_DISCARD;
          op_start_reg <= 1'b1;
          op_reg <= cmt_pkg::OP_RX_BUF;
        end
        cmt_pkg::M_DISCARD, cmt_pkg::M_TX_POLL: if (op_done) begin
          xie_reg <= op_rdata[`CMT_TXIE_BIT];
          op_start_reg <= 1'b1;
          op_wdata_reg <= q_reg[head_reg];
          if (st_reg == cmt_pkg::M_TX_POLL && op_rdata[`CMT_DONE_BIT]) begin
            st_reg <= cmt_pkg::M_TX_WRITE;
            op_reg <= cmt_pkg::OP_TX_BUF;
          end else begin
            st_reg <= cmt_pkg::M_TX_POLL;
            op_reg <= cmt_pkg::OP_TX_STAT;
          end
        end
        cmt_pkg::M_TX_WRITE: if (op_done) begin
          head_reg <= head_reg + 4'h1;
          op_start_reg <= 1'b1;
          if (head_reg + 4'h1 != len_reg) begin
            st_reg <= cmt_pkg::M_TX_POLL;
            op_reg <= cmt_pkg::OP_TX_STAT;
          end else if (exit_reg) begin
            op_start_reg <= 1'b0;
            st_reg <= cmt_pkg::M_IDLE;
            console_mode <= 1'b0;
            resume_pulse <= 1'b1;
            go_clear_ie <= go_reg;
            sw_irq_req <= !go_reg && xie_reg;
          end else begin
            st_reg <= cmt_pkg::M_RX_POLL;
            op_reg <= cmt_pkg::OP_RX_STAT;
          end
        end
        cmt_pkg::M_RX_POLL: if (op_done) begin
          op_start_reg <= 1'b1;
          if (op_rdata[`CMT_DONE_BIT]) begin
            st_reg <= cmt_pkg::M_RX_READ;
            op_reg <= cmt_pkg::OP_RX_BUF;
          end else begin
            op_reg <= cmt_pkg::OP_RX_STAT;
          end
        end
        cmt_pkg::M_RX_READ: if (op_done) begin
          last_ch_reg <= op_rdata[7:0];
          q_reg <= ld_q;
          len_reg <= ld_len;
          head_reg <= 4'h0;
          ps_reg <= ps_next;
          addr_reg <= addr_next;
          data_reg <= data_next;
          deposit <= ld_dep;
          exit_reg <= ld_exit;
          go_reg <= ld_go;
          if (ps_next == cmt_pkg::PS_OPEN) loc_seen_reg <= 1'b1;
          st_reg <= cmt_pkg::M_TX_POLL;
          op_start_reg <= 1'b1;
          op_reg <= cmt_pkg::OP_TX_STAT;
        end
        default: st_reg <= cmt_pkg::M_IDLE;
      endcase
    end
  end

  assign loc_addr = addr_reg;
  assign loc_data = data_reg;

  cmt_pkg::cmt_bus_t bus_w;
  cmt_bus_poll u_bus (
    .pclk(pclk), .presetn(presetn), .ce(ce),
    .op_start(op_start_reg), .op(op_reg), .op_wdata(op_wdata_reg),
    .op_done(op_done), .op_rdata(op_rdata),
    .bus_req(bus_req), .bus_o(bus_w),
    .bus_ack(bus_ack), .bus_rdata(bus_rdata)
  );
  assign bus_addr = bus_w.addr;
  assign bus_we = bus_w.we;
  assign bus_wdata = bus_w.wdata;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_entry_discard;
    (ce && st_reg == cmt_pkg::M_IDLE && entry) |=>
      (op_start_reg && op_reg == cmt_pkg::OP_RX_BUF && console_mode);
  endproperty
  a_entry_discard: assert property (p_entry_discard) else $error("no discard on entry");
  property p_no_jumper;
    (ce && st_reg == cmt_pkg::M_IDLE && halt_exec && !pin_s2_reg[0]
      && !(pin_s2_reg[1] && macro_end) && !pu_req_reg) |=> !console_mode;
  endproperty
  a_no_jumper: assert property (p_no_jumper) else $error("halt entered without jumper");
  property p_init_text;
    (st_reg == cmt_pkg::M_DISCARD) |-> (q_reg[0] == 8'h0d && q_reg[1] == 8'h0a
      && q_reg[8] == 8'h0d && q_reg[10] == 8'h40 && len_reg == 4'hb);
  endproperty
  a_init_text: assert property (p_init_text) else $error("bad entry text");
  property p_rx_poll;
    (ce && st_reg == cmt_pkg::M_RX_POLL && op_done && !op_rdata[7]) |=>
      (st_reg == cmt_pkg::M_RX_POLL && op_reg == cmt_pkg::OP_RX_STAT && op_start_reg);
  endproperty
  a_rx_poll: assert property (p_rx_poll) else $error("receive poll not repeated");
  property p_rx_read;
    (ce && st_reg == cmt_pkg::M_RX_POLL && op_done && op_rdata[7]) |=>
      (st_reg == cmt_pkg::M_RX_READ && op_reg == cmt_pkg::OP_RX_BUF);
  endproperty
  a_rx_read: assert property (p_rx_read) else $error("no buffer read after done");
  property p_tx_poll;
    (ce && st_reg == cmt_pkg::M_TX_POLL && op_done && !op_rdata[7]) |=>
      (op_reg == cmt_pkg::OP_TX_STAT && op_start_reg);
  endproperty
  a_tx_poll: assert property (p_tx_poll) else $error("write before transmit done");
  property p_tx_char;
    (ce && st_reg == cmt_pkg::M_TX_POLL && op_done && op_rdata[7]) |=>
      (op_reg == cmt_pkg::OP_TX_BUF && op_wdata_reg == q_reg[head_reg]);
  endproperty
  a_tx_char: assert property (p_tx_char) else $error("wrong transmit character");
  property p_go_quiet;
    go_clear_ie |-> (!sw_irq_req && resume_pulse && !console_mode);
  endproperty
  a_go_quiet: assert property (p_go_quiet) else $error("go raised an interrupt");
  c_entry: cover property (st_reg == cmt_pkg::M_IDLE ##1 st_reg == cmt_pkg::M_DISCARD);
  c_char_in: cover property (st_reg == cmt_pkg::M_RX_READ && op_done);
  c_resume: cover property (resume_pulse);
endmodule : cmt_console_poller

/* File: logic/cmt_consts.svh */
// constants for the console monitor terminal poller
// assumes: included by bare name from the design files
`ifndef CMT_CONSTS_SVH
`define CMT_CONSTS_SVH

// fixed terminal register and psw addresses on the backplane
`define CMT_ADDR_RX_STAT 22'h3f_ff70
`define CMT_ADDR_RX_BUF 22'h3f_ff72
`define CMT_ADDR_TX_STAT 22'h3f_ff74
`define CMT_ADDR_TX_BUF 22'h3f_ff76
`define CMT_ADDR_PSW 22'h3f_fffe
`define CMT_DONE_BIT 7
`define CMT_TXIE_BIT 6

// apb register offsets
`define CMT_OFF_CTRL 8'h00
`define CMT_OFF_STATUS 8'h04
`define CMT_OFF_ADDR 8'h08
`define CMT_OFF_CONTENT 8'h0c
`define CMT_CTRL_VIRT_BIT 0

// characters, 7-bit codes
`define CMT_CH_CR 7'h0d
`define CMT_CH_LF 7'h0a
`define CMT_CH_AT 7'h40
`define CMT_CH_QM 7'h3f
`define CMT_CH_SP 7'h20
`define CMT_CH_SLASH 7'h2f
`define CMT_CH_DOLLAR 7'h24
`define CMT_CH_R 7'h52
`define CMT_CH_S 7'h53
`define CMT_CH_G 7'h47
`define CMT_CH_P 7'h50
`define CMT_CH_ZERO 7'h30

`define CMT_PU_MODE_MON 2'h1
`define CMT_QDEPTH 12
`define CMT_PU_SETTLE 2'h3

`endif

/* File: logic/cmt_pkg.sv */
// types for the console monitor terminal poller
// assumes: nothing beyond the constants header
package cmt_pkg;
  typedef enum logic [2:0] {
    M_IDLE = 3'h0, M_DISCARD = 3'h1, M_TX_POLL = 3'h3,
    M_TX_WRITE = 3'h2, M_RX_POLL = 3'h6, M_RX_READ = 3'h7
  } cmt_main_t;
  typedef enum logic [2:0] {
    PS_PROMPT = 3'h0, PS_ADDR = 3'h1, PS_REGDES = 3'h3,
    PS_REGNUM = 3'h2, PS_OPEN = 3'h6, PS_DATA = 3'h7
  } cmt_parse_t;
  typedef enum logic [1:0] {
    OP_RX_STAT = 2'h0, OP_RX_BUF = 2'h1, OP_TX_STAT = 2'h2, OP_TX_BUF = 2'h3
  } cmt_op_t;
  typedef enum logic [1:0] {B_IDLE = 2'h0, B_REQ = 2'h1, B_DROP = 2'h3} cmt_bus_st_t;
  typedef struct packed {
    logic [21:0] addr;
    logic we;
    logic [15:0] wdata;
  } cmt_bus_t;
endpackage : cmt_pkg

/* File: logic/cmt_bus_poll.sv */
// one backplane bus cycle at a time, four-phase req/ack
// assumes: ack comes from the backplane, rdata stable while ack high
`timescale 1ns/100ps
`include "cmt_consts.svh"
module cmt_bus_poll (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic op_start,
  input wire cmt_pkg::cmt_op_t op,
  input wire logic [7:0] op_wdata,
  output logic op_done,
  output logic [15:0] op_rdata,
  output logic bus_req,
  output cmt_pkg::cmt_bus_t bus_o,
  input wire logic bus_ack,
  input wire logic [15:0] bus_rdata
);
  cmt_pkg::cmt_bus_st_t st_reg;
  logic ack_s1_reg, ack_s2_reg;

  function automatic logic [21:0] op_addr(input cmt_pkg::cmt_op_t o);
    unique case (o)
      cmt_pkg::OP_RX_STAT: op_addr = `CMT_ADDR_RX_STAT;
      cmt_pkg::OP_RX_BUF: op_addr = `CMT_ADDR_RX_BUF;
      cmt_pkg::OP_TX_STAT: op_addr = `CMT_ADDR_TX_STAT;
      cmt_pkg::OP_TX_BUF: op_addr = `CMT_ADDR_TX_BUF;
    endcase
  endfunction : op_addr

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_s1_reg <= 1'b0;
      ack_s2_reg <= 1'b0;
    end else if (ce) begin
      ack_s1_reg <= bus_ack;
      ack_s2_reg <= ack_s1_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= cmt_pkg::B_IDLE;
      op_done <= 1'b0;
      op_rdata <= 16'h0000;
      bus_req <= 1'b0;
      bus_o <= '0;
    end else if (ce) begin
      op_done <= 1'b0;
      unique case (st_reg)
        cmt_pkg::B_IDLE: if (op_start) begin
          bus_req <= 1'b1;
          bus_o.addr <= op_addr(op);
          bus_o.we <= (op == cmt_pkg::OP_TX_BUF);
          bus_o.wdata <= {8'h00, op_wdata};
          st_reg <= cmt_pkg::B_REQ;
        end
        cmt_pkg::B_REQ: if (ack_s2_reg) begin
          op_rdata <= bus_rdata;
          bus_req <= 1'b0;
          st_reg <= cmt_pkg::B_DROP;
        end
        cmt_pkg::B_DROP: if (!ack_s2_reg) begin
          op_done <= 1'b1;
          st_reg <= cmt_pkg::B_IDLE;
        end
        default: st_reg <= cmt_pkg::B_IDLE;
      endcase
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_one_cycle;
    (ce && op_start) |-> (st_reg == cmt_pkg::B_IDLE && !bus_req);
  endproperty
  a_one_cycle: assert property (p_one_cycle)
    else $error("bus cycle started while another in flight");
  property p_req_hold;
    (ce && bus_req && !ack_s2_reg) |=> (bus_req && $stable(bus_o));
  endproperty
  a_req_hold: assert property (p_req_hold)
    else $error("bus request dropped before ack");
  property p_fixed_addr;
    bus_req |-> (bus_o.addr[21:3] == `CMT_ADDR_RX_STAT >> 3);
  endproperty
  a_fixed_addr: assert property (p_fixed_addr)
    else $error("bus address outside terminal registers");
endmodule : cmt_bus_poll

/* File: testbench/cmt_serial_model.sv */
// serial-line interface model answering backplane cycles four-phase
// assumes: requests held until ack seen, a single request in flight at a time
`timescale 1ns/100ps
module cmt_serial_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic bus_req,
  input wire logic [21:0] bus_addr,
  input wire logic bus_we,
  input wire logic [15:0] bus_wdata,
  output logic bus_ack,
  output logic [15:0] bus_rdata,
  input wire logic rx_load,
  input wire logic [7:0] rx_char,
  output logic op_valid,
  output logic [38:0] op_log
);
  logic [15:0] last, rd_val;
  logic [7:0] rx_hold;
  logic rx_full, tx_rdy;
  int wait_n;
  // released data lines show the inverse of the last word
  assign bus_rdata = bus_ack ? last : ~last;
  always_comb begin
    case (bus_addr)
      22'h3f_ff70: rd_val = {8'h80, rx_full, 7'h00};
      22'h3f_ff72: rd_val = {8'h5a, rx_hold};
      22'h3f_ff74: rd_val = {8'h00, tx_rdy, 7'h00};
      default: rd_val = 16'h0000;
    endcase
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_ack <= 1'b0;
      last <= 16'h0000;
      rx_full <= 1'b0;
      rx_hold <= 8'h00;
      tx_rdy <= 1'b0;
      wait_n <= 0;
      op_valid <= 1'b0;
      op_log <= '0;
    end else begin
      op_valid <= 1'b0;
      if (rx_load) begin
        rx_full <= 1'b1;
        rx_hold <= rx_char;
      end
      if (bus_req && !bus_ack) begin
        if (wait_n < 2) begin
          wait_n <= wait_n + 1 + int'($urandom % 2);
        end else begin
          wait_n <= 0;
          bus_ack <= 1'b1;
          last <= rd_val;
          op_valid <= 1'b1;
          // high byte of a write dropped
          op_log <= {bus_we, bus_addr, bus_we ? {8'h00, bus_wdata[7:0]} : rd_val};
          if (bus_addr == 22'h3f_ff72 && !bus_we) rx_full <= 1'b0;
          if (bus_addr == 22'h3f_ff74) tx_rdy <= !tx_rdy;
          if (bus_addr == 22'h3f_ff76) tx_rdy <= 1'b0;
        end
      end else if (!bus_req && bus_ack) begin
        bus_ack <= 1'b0;
      end
    end
  end
endmodule : cmt_serial_model

/* File: testbench/console_monitor_terminal_poller_tb.sv */
// testbench: entry, print, echo, go and halt entry of the console poller
// assumes: serial model on the backplane, apb master driven on pclk edges
`timescale 1ns/100ps
module console_monitor_terminal_poller_tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [7:0] paddr = 8'h00, rx_char = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, r;
  logic halt_exec = 0, kernel_mode = 0, jumper = 0, rx_load = 0, e, op_valid;
  logic hreq = 0, mend = 0;
  logic [15:0] ip = 16'h0000, bus_wdata, bus_rdata;
  logic [1:0] pu_mode = 2'h1;
  logic bus_req, bus_we, bus_ack, console_mode, resume_pulse, go_clear_ie, sw_irq_req;
  logic loc_virtual;
  logic [21:0] bus_addr, la;
  logic [38:0] op_log, op;
  logic [38:0] opq[$];
  int num_errors = 0, n_checks = 0, t;
  always #5 pclk = ~pclk;
  cmt_console_poller uut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .halt_exec(halt_exec), .kernel_mode(kernel_mode),
    .macro_end(mend), .instruction_pointer(ip), .halt_trap_jumper(jumper),
    .halt_request_line(hreq), .power_up_mode(pu_mode), .bus_ack(bus_ack),
    .bus_rdata(bus_rdata), .bus_req(bus_req), .bus_addr(bus_addr), .bus_we(bus_we),
    .bus_wdata(bus_wdata), .console_mode(console_mode), .resume_pulse(resume_pulse),
    .go_clear_ie(go_clear_ie), .sw_irq_req(sw_irq_req), .loc_addr(la), .loc_virtual(loc_virtual),
    .loc_data(), .deposit());
  cmt_serial_model model (.pclk(pclk), .presetn(presetn), .bus_req(bus_req),
    .bus_addr(bus_addr), .bus_we(bus_we), .bus_wdata(bus_wdata), .bus_ack(bus_ack),
    .bus_rdata(bus_rdata), .rx_load(rx_load), .rx_char(rx_char), .op_valid(op_valid),
    .op_log(op_log));
  always @(posedge pclk) if (op_valid) opq.push_back(op_log);
  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input string nm, input logic [22:0] exp, input logic [22:0] got);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic pop(output logic [38:0] o);
    int w;
    w = 0;
    while (opq.size() == 0 && w < 3000) begin
      @(posedge pclk);
      w++;
    end
    if (opq.size() == 0) begin
      num_errors++;
      o = '0;
    end else o = opq.pop_front();
  endtask : pop
  task automatic get_char(input logic [7:0] exp);
    int polls;
    polls = 0;
    pop(op);
    while (op[37:16] == 22'h3f_ff74) begin
      polls++;
      pop(op);
    end
    chk("tx polls", 23'd2, 23'(polls));
    chk("tx write", {1'b1, 22'h3f_ff76}, op[38:16]);
    chk("tx char", {15'h0, exp}, {7'h0, op[15:0]});
  endtask : get_char
  task automatic expect_entry(input logic [15:0] v);
    pop(op);
    chk("discard read", {1'b0, 22'h3f_ff72}, op[38:16]);
    get_char(8'h0d);
    get_char(8'h0a);
    for (int i = 5; i >= 0; i--) get_char(8'h30 + 8'((v >> (3 * i)) & 7));
    get_char(8'h0d);
    get_char(8'h0a);
    get_char(8'h40);
    for (int i = 0; i < 2; i++) begin
      pop(op);
      chk("rx poll", {1'b0, 22'h3f_ff70}, op[38:16]);
    end
  endtask : expect_entry
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic load(input logic [7:0] c);
    rx_char <= c;
    rx_load <= 1'b1;
    @(posedge pclk);
    rx_load <= 1'b0;
    pop(op);
    while (op[37:16] == 22'h3f_ff70) pop(op);
    chk("rx read", {1'b0, 22'h3f_ff72}, op[38:16]);
  endtask : load
  task automatic resume_chk(input logic [22:0] exp);
    t = 0;
    while (resume_pulse !== 1'b1 && t < 3000) begin
      @(negedge pclk);
      t++;
    end
    chk("exit kind", exp, {20'h0, resume_pulse, go_clear_ie, sw_irq_req});
    repeat (2) @(posedge pclk);
    chk("exit", 23'h0, {22'h0, console_mode});
  endtask : resume_chk
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : tally_and_finish
  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial begin
    repeat (30000) @(posedge pclk);
    num_errors++;
    tally_and_finish();
  end
  initial begin
    r = 32'($urandom(73976));
    ip = 16'($urandom);
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    expect_entry(ip);
    pu_mode <= 2'h0;
    apb(1'b0, 8'h04, 32'h0000_0000);
    chk("status mode", 23'h1, {22'h0, r[8]});
    apb(1'b0, 8'h10, 32'h0000_0000);
    chk("unmapped", 23'h20_0000, {1'b0, e, r[20:0]});
    apb(1'b1, 8'h00, 32'h0000_0001);
    repeat (2) @(posedge pclk);
    chk("virtual", 23'h1, {22'h0, loc_virtual});
    load(8'hb1);
    get_char(8'hb1);
    load(8'hc7);
    get_char(8'hc7);
    resume_chk(23'h6);
    chk("loc addr", 23'h1, {1'b0, la});
    kernel_mode <= 1'b1;
    halt_exec <= 1'b1;
    @(posedge pclk);
    halt_exec <= 1'b0;
    repeat (20) @(posedge pclk);
    chk("no jumper", 23'h0, {22'h0, console_mode});
    hreq <= 1'b1;
    repeat (6) @(posedge pclk);
    chk("halt level", 23'h0, {22'h0, console_mode});
    mend <= 1'b1;
    @(posedge pclk);
    mend <= 1'b0;
    expect_entry(ip);
    hreq <= 1'b0;
    load(8'h47);
    get_char(8'h3f);
    get_char(8'h0d);
    get_char(8'h0a);
    get_char(8'h40);
    load(8'h50);
    get_char(8'h50);
    resume_chk(23'h4);
    jumper <= 1'b1;
    ip <= 16'($urandom);
    repeat (4) @(posedge pclk);
    opq.delete();
    halt_exec <= 1'b1;
    @(posedge pclk);
    halt_exec <= 1'b0;
    expect_entry(ip);
    tally_and_finish();
  end
endmodule : console_monitor_terminal_poller_tb
